//--- pssc_consts.svh
// ============================================================
// power step sequencer constants
// ============================================================
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz reference clock
// Notes:   definitions only
`ifndef PSSC_CONSTS_SVH
`define PSSC_CONSTS_SVH

// register offsets (word index on the configuration port)
`define PSSC_OFS_WORD_D      8'h0d
`define PSSC_OFS_RAIL_STEP   8'h0e
`define PSSC_OFS_PU_DELAY    8'h0f
`define PSSC_OFS_RST_PGWAIT  8'h10

// word layout
`define PSSC_WORD_W          24
`define PSSC_CRC_HI          3
`define PSSC_CRC_LO          0
`define PSSC_FIELD_LO        4
`define PSSC_FIELD_HI        19
`define PSSC_RESET_WORD      24'h000000

// rail step word fields
`define PSSC_REPEAT_BIT      19
`define PSSC_B_RECOVER_BIT   18
`define PSSC_B_TRACK_HI      17
`define PSSC_B_TRACK_LO      16
`define PSSC_B_OFF_LO        13
`define PSSC_B_ON_LO         10
`define PSSC_A_OFF_LO        7
`define PSSC_A_ON_LO         4

// delay word: step s occupies bits 2s+3 .. 2s+2
`define PSSC_DLY_BASE        2
// reset / power-good word fields; pg wait for step s at bit s+3
`define PSSC_RST_ASSERT_LO   14
`define PSSC_RST_RELEASE_LO  11
`define PSSC_PGWAIT_BASE     3

// step codes
`define PSSC_STEP_NONE       3'h0
`define PSSC_STEP_LAST       3'h7
`define PSSC_OFF_CLAMP       3'h6

// power-up delays in ms per 2-bit code
`define PSSC_DLY_MS_0        4'h0
`define PSSC_DLY_MS_1        4'h2
`define PSSC_DLY_MS_2        4'h5
`define PSSC_DLY_MS_3        4'ha

// timing
`define PSSC_MS_NS           1000000
`define PSSC_CLK_NS          10
`define PSSC_TICK_CYCLES     (`PSSC_MS_NS / `PSSC_CLK_NS)

`endif

//--- pssc_pkg.sv
// ============================================================
// power step sequencer types
// ============================================================
// Purpose: shared types of the sequencer
// Assumes: nothing
// Notes:   constants live in pssc_consts.svh
package pssc_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      PSSC_IDLE    = 3'b000,
      PSSC_UP_EN   = 3'b001,
      PSSC_UP_PG   = 3'b010,
      PSSC_UP_DLY  = 3'b011,
      PSSC_ON      = 3'b100,
      PSSC_DOWN    = 3'b101
   } pssc_state_t;

   // fault group of the second linear regulator
   typedef struct packed {
      logic undervoltage_fault;
      logic overvoltage_fault;
      logic power_good_lost;
      logic thermal_warning;
      logic thermal_shutdown;
   } pssc_fault_t;

endpackage

//--- pssc_sync.sv
// ============================================================
// two-stage synchroniser
// ============================================================
// Purpose: bring pin levels into the reference clock domain
// Assumes: inputs are levels
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
module pssc_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         rst_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] stage1;

   generate
      if (W < 1) begin : g_chk
         $error("pssc_sync width must be at least one");
      end
   endgenerate

   // two flops in series
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stage1 <= '0;
         q_out  <= '0;
      end else begin
         stage1 <= d_in;
         q_out  <= stage1;
      end
   end
endmodule

//--- pssc_delay_timer.sv
// ============================================================
// millisecond delay timer
// ============================================================
// Purpose: wait 0, 2, 5 or 10 ms after a start pulse
// Assumes: start only while idle
// Notes:   done is a one-cycle pulse
`timescale 1ns/1ns
`include "pssc_consts.svh"
module pssc_delay_timer #(
   parameter int unsigned TICK_CYCLES = `PSSC_TICK_CYCLES
) (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   // request
   input  wire logic       start_in,
   input  wire logic [1:0] code_in,
   // answer
   output logic            done_out
);
   localparam int unsigned DW = $clog2(TICK_CYCLES + 1);
   localparam logic [DW-1:0] TICK_LAST = DW'(TICK_CYCLES - 1);

   logic [DW-1:0] div;
   logic [DW-1:0] next_div;
   logic [3:0]    ms_left;
   logic [3:0]    next_ms_left;
   logic          run;
   logic          next_run;
   logic          next_done;
   logic [3:0]    start_ms;

   generate
      if (TICK_CYCLES < 1) begin : g_chk
         $error("pssc_delay_timer needs at least one cycle per ms");
      end
   endgenerate

   // code to milliseconds
   always_comb begin
      case (code_in)
         2'h0:    start_ms = `PSSC_DLY_MS_0;
         2'h1:    start_ms = `PSSC_DLY_MS_1;
         2'h2:    start_ms = `PSSC_DLY_MS_2;
         default: start_ms = `PSSC_DLY_MS_3;
      endcase
   end

   // next values of divider and ms count
   always_comb begin
      next_div     = div;
      next_ms_left = ms_left;
      next_run     = run;
      next_done    = 1'b0;
      if (start_in) begin
         next_div     = '0;
         next_ms_left = start_ms;
         next_run     = (start_ms != 4'h0);
         next_done    = (start_ms == 4'h0);
      end else if (run) begin
         if (div == TICK_LAST) begin
            next_div = '0;
            if (ms_left == 4'h1) begin
               next_run  = 1'b0;
               next_done = 1'b1;
            end
            next_ms_left = ms_left - 4'h1;
         end else begin
            next_div = div + DW'(1);
         end
      end
   end

   // register
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         div      <= '0;
         ms_left  <= 4'h0;
         run      <= 1'b0;
         done_out <= 1'b0;
      end else begin
         div      <= next_div;
         ms_left  <= next_ms_left;
         run      <= next_run;
         done_out <= next_done;
      end
   end
endmodule

//--- pssc_sequencer.sv
// ============================================================
// power step sequencer, linear rails and mcu reset
// ============================================================
// Purpose: seven-step power-up/down of two linear rails and mcu reset
// Assumes: configuration words loaded from user nvm after reset
// Notes:   one reference clock; pins pass two flops
//
// What this block does
// - A linear rail on-step code of 000 keeps the rail off and 001..111 switch it on at steps 1..7.
// - A linear rail off-step code 000..101 turns it off at steps 1..6 and 110 or 111 at step 7.
// - With the recover bit set, any fault of rail b while rail b is enabled outside a running power-down starts power-down and enters recovery state two.
// - With the recover bit clear, a rail b fault raises the interrupt, all but thermal shutdown maskable.
// - With the recover bit clear, unmasked undervoltage or power-good-lost, or any overvoltage or shutdown, turns rail b off.
// - Each power-up step waits an extra 0, 2, 5 or 10 ms according to its 2-bit delay code.
// - A set power-good wait bit holds its power-up step until power-good is present.
// - The mcu reset asserts at power-down step 1..6 for codes 000..101 and at step 7 for 11x.
// - The mcu reset releases and the watchdog starts at step 1..7, or after step 7 for code 000.
// - Configuration words may be overridden by emulation only in user programming state one.
// - Each configuration word keeps a 4-bit check code in bits 3..0 under its fields.
`timescale 1ns/1ns
`include "pssc_consts.svh"
module pssc_sequencer #(
   parameter int unsigned TICK_CYCLES = `PSSC_TICK_CYCLES
) (
   // clock and reset
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_in,
   // nvm load and emulation
   input  wire logic                  nvm_load_in,
   input  wire logic [7:0]            nvm_addr_in,
   input  wire logic [23:0]           nvm_data_in,
   input  wire logic                  user_program_state_one_in,
   input  wire logic                  emu_wr_in,
   input  wire logic [7:0]            emu_addr_in,
   input  wire logic [23:0]           emu_data_in,
   // configuration read back
   input  wire logic [7:0]            rd_addr_in,
   output logic      [23:0]           rd_data_out,
   // sequence requests
   input  wire logic                  power_up_req_in,
   input  wire logic                  power_down_req_in,
   // pins from the rails
   input  wire logic                  power_good_in,
   input  wire pssc_pkg::pssc_fault_t linear_b_fault_in,
   // serial interface masks
   input  wire pssc_pkg::pssc_fault_t irq_mask_in,
   input  wire logic                  off_mask_uv_in,
   input  wire logic                  off_mask_pgl_in,
   // outputs
   output logic                       linear_reg_a_en_out,
   output logic                       linear_reg_b_en_out,
   output logic                       mcu_reset_out,
   output logic                       watchdog_start_out,
   output logic                       linear_b_irq_out,
   output logic                       recovery_state_two_out,
   output pssc_pkg::pssc_state_t      state_out,
   output logic      [2:0]            step_out
);
   import pssc_pkg::*;

   // ============================================================
   // configuration words
   // ============================================================
   logic [23:0] word_d;
   logic [23:0] word_e;
   logic [23:0] word_f;
   logic [23:0] word_g;
   logic [23:0] next_word_d;
   logic [23:0] next_word_e;
   logic [23:0] next_word_f;
   logic [23:0] next_word_g;
   logic [23:0] next_rd_data;
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [23:0] wr_data;

   // emulation only in programming state one, nvm load otherwise
   always_comb begin
      wr_en   = nvm_load_in;
      wr_addr = nvm_addr_in;
      wr_data = nvm_data_in;
      if (emu_wr_in && user_program_state_one_in) begin
         wr_en   = 1'b1;
         wr_addr = emu_addr_in;
         wr_data = emu_data_in;
      end
   end

   // word update, reserved bits forced to zero
   always_comb begin
      next_word_d = word_d;
      next_word_e = word_e;
      next_word_f = word_f;
      next_word_g = word_g;
      if (wr_en) begin
         case (wr_addr)
            `PSSC_OFS_WORD_D:     next_word_d = {4'h0, wr_data[19:0]};
            `PSSC_OFS_RAIL_STEP:  next_word_e = {4'h0, wr_data[19:0]};
            `PSSC_OFS_PU_DELAY:   next_word_f = {4'h0, wr_data[19:0]};
            `PSSC_OFS_RST_PGWAIT: next_word_g = {4'h0, wr_data[19:0]};
            default:              next_word_d = word_d;
         endcase
      end
   end

   // read back, unmapped reads zero
   always_comb begin
      case (rd_addr_in)
         `PSSC_OFS_WORD_D:     next_rd_data = word_d;
         `PSSC_OFS_RAIL_STEP:  next_rd_data = word_e;
         `PSSC_OFS_PU_DELAY:   next_rd_data = word_f;
         `PSSC_OFS_RST_PGWAIT: next_rd_data = word_g;
         default:              next_rd_data = 24'h000000;
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         word_d      <= `PSSC_RESET_WORD;
         word_e      <= `PSSC_RESET_WORD;
         word_f      <= `PSSC_RESET_WORD;
         word_g      <= `PSSC_RESET_WORD;
         rd_data_out <= 24'h000000;
      end else begin
         word_d      <= next_word_d;
         word_e      <= next_word_e;
         word_f      <= next_word_f;
         word_g      <= next_word_g;
         rd_data_out <= next_rd_data;
      end
   end

   // ============================================================
   // field decode
   // ============================================================
   logic [2:0] linear_a_on_step;
   logic [2:0] linear_b_on_step;
   logic [2:0] linear_a_off_step;
   logic [2:0] linear_b_off_step;
   logic [2:0] mcu_reset_assert_step;
   logic [2:0] mcu_reset_release_step;
   logic       linear_b_fault_recover;
   logic [6:0] powerup_step_good_wait;

   // off-step code to step number, 11x clamps to 7
   function automatic logic [2:0] off_code_to_step(input logic [2:0] code);
      logic [2:0] s;
      s = (code >= `PSSC_OFF_CLAMP) ? `PSSC_STEP_LAST : code + 3'h1;
      return s;
   endfunction

   assign linear_a_on_step       = word_e[`PSSC_A_ON_LO +: 3];
   assign linear_b_on_step       = word_e[`PSSC_B_ON_LO +: 3];
   assign linear_a_off_step      = off_code_to_step(word_e[`PSSC_A_OFF_LO +: 3]);
   assign linear_b_off_step      = off_code_to_step(word_e[`PSSC_B_OFF_LO +: 3]);
   assign mcu_reset_assert_step  = off_code_to_step(word_g[`PSSC_RST_ASSERT_LO +: 3]);
   assign mcu_reset_release_step = word_g[`PSSC_RST_RELEASE_LO +: 3];
   assign linear_b_fault_recover = word_e[`PSSC_B_RECOVER_BIT];
   assign powerup_step_good_wait = word_g[`PSSC_PGWAIT_BASE + 1 +: 7];

   // ============================================================
   // pin synchronisers
   // ============================================================
   logic        pg_sync;
   pssc_fault_t fault_sync;

   pssc_sync #(.W(1)) u_pg_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .d_in       (power_good_in),
      .q_out      (pg_sync)
   );

   pssc_sync #(.W($bits(pssc_fault_t))) u_fault_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .d_in       (linear_b_fault_in),
      .q_out      (fault_sync)
   );

   // ============================================================
   // linear rail b fault reaction
   // ============================================================
   logic any_fault;
   logic irq_fault;
   logic off_fault;
   logic recover_hit;

   // interrupt: all maskable but thermal shutdown
   assign irq_fault = (fault_sync.undervoltage_fault & ~irq_mask_in.undervoltage_fault) |
                      (fault_sync.overvoltage_fault  & ~irq_mask_in.overvoltage_fault)  |
                      (fault_sync.power_good_lost    & ~irq_mask_in.power_good_lost)    |
                      (fault_sync.thermal_warning    & ~irq_mask_in.thermal_warning)    |
                      fault_sync.thermal_shutdown;
   // switch-off: warning never, overvoltage and shutdown always
   assign off_fault = (fault_sync.undervoltage_fault & ~off_mask_uv_in) |
                      (fault_sync.power_good_lost    & ~off_mask_pgl_in) |
                      fault_sync.overvoltage_fault | fault_sync.thermal_shutdown;
   assign any_fault   = |fault_sync;
   assign recover_hit = linear_b_fault_recover && any_fault && linear_reg_b_en_out;

   // ============================================================
   // sequencer
   // ============================================================
   pssc_state_t state;
   pssc_state_t next_state;
   logic [2:0]  step;
   logic [2:0]  next_step;
   logic        next_a_en;
   logic        next_b_en;
   logic        next_reset;
   logic        next_wd;
   logic        next_irq;
   logic        next_rec;
   logic        dly_start;
   logic        dly_done;
   logic [1:0]  dly_code;

   assign dly_code = word_f[(`PSSC_DLY_BASE + 2 * step) +: 2];

   pssc_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) u_delay (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .start_in   (dly_start),
      .code_in    (dly_code),
      .done_out   (dly_done)
   );

   // next state and outputs
   always_comb begin
      next_state = state;
      next_step  = step;
      next_a_en  = linear_reg_a_en_out;
      next_b_en  = linear_reg_b_en_out;
      next_reset = mcu_reset_out;
      next_wd    = 1'b0;
      next_rec   = 1'b0;
      next_irq   = !linear_b_fault_recover && irq_fault;
      dly_start  = 1'b0;
      if (!linear_b_fault_recover && off_fault) begin
         next_b_en = 1'b0;
      end
      case (state)
         PSSC_IDLE: begin
            if (power_up_req_in) begin
               next_state = PSSC_UP_EN;
               next_step  = 3'h1;
            end
         end
         PSSC_UP_EN: begin
            // step enables; 000 never matches a step
            if (linear_a_on_step == step) begin
               next_a_en = 1'b1;
            end
            if (linear_b_on_step == step) begin
               next_b_en = 1'b1;
            end
            if (mcu_reset_release_step == step) begin
               next_reset = 1'b0;
               next_wd    = 1'b1;
            end
            next_state = PSSC_UP_PG;
         end
         PSSC_UP_PG: begin
            if (!powerup_step_good_wait[step - 3'h1] || pg_sync) begin
               dly_start  = 1'b1;
               next_state = PSSC_UP_DLY;
            end
         end
         PSSC_UP_DLY: begin
            if (dly_done) begin
               if (step == `PSSC_STEP_LAST) begin
                  next_state = PSSC_ON;
                  if (mcu_reset_release_step == `PSSC_STEP_NONE) begin
                     next_reset = 1'b0;
                     next_wd    = 1'b1;
                  end
               end else begin
                  next_step  = step + 3'h1;
                  next_state = PSSC_UP_EN;
               end
            end
         end
         PSSC_ON: begin
            if (power_down_req_in) begin
               next_state = PSSC_DOWN;
               next_step  = 3'h1;
            end
         end
         PSSC_DOWN: begin
            if (linear_a_off_step == step) begin
               next_a_en = 1'b0;
            end
            if (linear_b_off_step == step) begin
               next_b_en = 1'b0;
            end
            if (mcu_reset_assert_step == step) begin
               next_reset = 1'b1;
            end
            if (step == `PSSC_STEP_LAST) begin
               next_state = PSSC_IDLE;
            end else begin
               next_step = step + 3'h1;
            end
         end
         default: begin
            next_state = PSSC_IDLE;
            next_step  = 3'h1;
         end
      endcase
      // recovery fault overrides next state and step, but not a running power-down
      if (recover_hit && state != PSSC_DOWN) begin
         next_state = PSSC_DOWN;
         next_step  = 3'h1;
         next_rec   = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state                  <= PSSC_IDLE;
         step                   <= 3'h1;
         linear_reg_a_en_out    <= 1'b0;
         linear_reg_b_en_out    <= 1'b0;
         mcu_reset_out          <= 1'b1;
         watchdog_start_out     <= 1'b0;
         linear_b_irq_out       <= 1'b0;
         recovery_state_two_out <= 1'b0;
      end else begin
         state                  <= next_state;
         step                   <= next_step;
         linear_reg_a_en_out    <= next_a_en;
         linear_reg_b_en_out    <= next_b_en;
         mcu_reset_out          <= next_reset;
         watchdog_start_out     <= next_wd;
         linear_b_irq_out       <= next_irq;
         recovery_state_two_out <= next_rec;
      end
   end

   // status view
   assign state_out = state;
   assign step_out  = step;
endmodule

//--- pssc_rail_model.sv
// ============================================================
// rail model
// ============================================================
// Purpose: power-good pin of the linear rails
// Assumes: pg rises LAG cycles after a rail is on
// Notes:   hold_in keeps pg low to stall a step
`timescale 1ns/1ns
module pssc_rail_model #(
   parameter int LAG = 3
) (
   // clock
   input  wire logic ref_clk_in,
   // rail enables and stall
   input  wire logic a_en_in,
   input  wire logic b_en_in,
   input  wire logic hold_in,
   // pin
   output logic      power_good_out
);
   logic [7:0] age;
   // cycles since a rail came on, saturating
   always_ff @(posedge ref_clk_in) begin
      age <= (a_en_in | b_en_in) ? age + 8'((age < 8'hff) ? 1 : 0) : 8'h0;
   end
   // pg low until the rail settles
   assign power_good_out = !hold_in && (age >= 8'(LAG));
endmodule

//--- pssc_sequencer_asserts.sv
// ============================================================
// sequencer checker
// ============================================================
// Purpose: port relations of the step sequencer
// Assumes: one clock domain
// Notes:   bound into every sequencer
`timescale 1ns/1ns
module pssc_sequencer_asserts (
   // clock and reset
   input wire logic                  ref_clk_in,
   input wire logic                  rst_in,
   // inputs watched
   input wire logic                  power_up_req_in,
   input wire logic                  power_down_req_in,
   input wire pssc_pkg::pssc_fault_t linear_b_fault_in,
   // outputs watched
   input wire logic [23:0]           rd_data_out,
   input wire logic                  linear_reg_a_en_out,
   input wire logic                  linear_reg_b_en_out,
   input wire logic                  mcu_reset_out,
   input wire logic                  watchdog_start_out,
   input wire logic                  linear_b_irq_out,
   input wire logic                  recovery_state_two_out,
   input wire pssc_pkg::pssc_state_t state_out,
   input wire logic [2:0]            step_out
);
   import pssc_pkg::*;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // sequence entry, walk and exit
   up_take_a: assert property (
      state_out == PSSC_IDLE && power_up_req_in |=> state_out == PSSC_UP_EN && step_out == 3'h1)
      else $error("power-up request not taken");
   en_then_pg_a: assert property (
      state_out == PSSC_UP_EN |=> recovery_state_two_out || state_out == PSSC_UP_PG && $stable(step_out))
      else $error("enable not followed by pg phase");
   down_take_a: assert property (
      state_out == PSSC_ON && power_down_req_in |=> state_out == PSSC_DOWN && step_out == 3'h1)
      else $error("power-down request not taken");
   down_end_a: assert property (
      state_out == PSSC_DOWN && step_out == 3'h7 |=> state_out == PSSC_IDLE
      ##1 (mcu_reset_out && !linear_reg_a_en_out && !linear_reg_b_en_out))
      else $error("power-down end left rails or reset wrong");
   // pulses, fault paths and reserved read-back bits
   wd_pulse_a: assert property (
      watchdog_start_out |-> !mcu_reset_out ##1 !watchdog_start_out)
      else $error("watchdog start pulse wrong");
   irq_cause_a: assert property (
      linear_b_irq_out |-> $past(linear_b_fault_in, 3) != '0)
      else $error("interrupt without fault");
   rec_down_a: assert property (
      recovery_state_two_out |-> ##[0:1] (state_out == PSSC_DOWN && step_out == 3'h1))
      else $error("recovery did not start power-down");
   rd_msb_a: assert property (
      rd_data_out[23:20] == 4'h0)
      else $error("reserved bits read nonzero");
endmodule
bind pssc_sequencer pssc_sequencer_asserts u_chk (.*);

//--- pssc_sequencer_tb.sv
// ============================================================
// sequencer testbench
// ============================================================
// Purpose: config port, power-up/down and fault paths
// Assumes: TICK of 4 cycles per ms
// Notes:   monitor logs rail steps
`timescale 1ns/1ns
`include "pssc_consts.svh"
module pssc_sequencer_tb;
   import pssc_pkg::*;
   localparam int TICK = 4;
   logic        ref_clk_in = 1'b0, rst_in = 1'b1;
   logic        ld = 1'b0, pso = 1'b0, ew = 1'b0, up = 1'b0, dn = 1'b0, hold = 1'b1;
   logic [7:0]  wa = 8'h0, ra = 8'h0;
   logic [23:0] wd = 24'h0, rd;
   pssc_fault_t flt = '0, imask = '0;
   logic        pg, a_en, b_en, mrst, irq, rec, rec_seen = 1'b0;
   pssc_state_t st;
   logic [2:0]  step, pstep, psig, sig, evp [6];
   int          dly [8] = '{default: 0};
   int          ms [8] = '{0, 0, 2, 0, 10, 5, 0, 0};
   int          err_count = 0, num_checks = 0;
   // clock
   always #5 ref_clk_in = ~ref_clk_in;
   pssc_sequencer #(.TICK_CYCLES(TICK)) u_dut (
      .ref_clk_in, .rst_in, .nvm_load_in(ld), .nvm_addr_in(wa), .nvm_data_in(wd),
      .user_program_state_one_in(pso), .emu_wr_in(ew), .emu_addr_in(wa), .emu_data_in(wd),
      .rd_addr_in(ra), .rd_data_out(rd), .power_up_req_in(up), .power_down_req_in(dn),
      .power_good_in(pg), .linear_b_fault_in(flt), .irq_mask_in(imask), .off_mask_uv_in(1'b0),
      .off_mask_pgl_in(1'b0), .linear_reg_a_en_out(a_en), .linear_reg_b_en_out(b_en),
      .mcu_reset_out(mrst), .watchdog_start_out(), .linear_b_irq_out(irq),
      .recovery_state_two_out(rec), .state_out(st), .step_out(step));
   pssc_rail_model #(.LAG(3)) u_rails (
      .ref_clk_in, .a_en_in(a_en), .b_en_in(b_en), .hold_in(hold), .power_good_out(pg));
   // step of rail and reset edges, delay cycles per step
   assign sig = {mrst, b_en, a_en};
   always @(posedge ref_clk_in) begin
      if (!rst_in) begin
         for (int i = 0; i < 3; i++) begin
            if (sig[i] !== psig[i]) begin
               evp[i + (sig[i] ? 0 : 3)] <= pstep;
            end
         end
         if (st == PSSC_UP_DLY) dly[step] <= dly[step] + 1;
         if (rec) rec_seen <= 1'b1;
      end
      psig <= sig;
      pstep <= step;
   end
   task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
      @(posedge ref_clk_in);
   endtask
   task automatic cmp_ev(input int i, input logic [2:0] e);
      cmp("event step", 24'(e), 24'(evp[i]));
   endtask
   task automatic wr(input logic emu, input logic [7:0] a, input logic [23:0] d);
      @(posedge ref_clk_in);
      ld <= !emu;
      ew <= emu;
      wa <= a;
      wd <= d;
      @(posedge ref_clk_in);
      ld <= 1'b0;
      ew <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [23:0] e);
      @(posedge ref_clk_in);
      ra <= a;
      repeat (2) @(posedge ref_clk_in);
      #1 cmp("config word", e, rd);
   endtask
   task automatic wait_st(input pssc_state_t s, input logic [2:0] k);
      int n = 0;
      do begin
         @(posedge ref_clk_in);
         #1 n++;
      end while (!(st === s && (k === 3'h0 || step === k)) && n < 400);
      cmp("state", 24'(s), 24'(st));
   endtask
   task automatic pulse_up_down(input logic d);
      @(posedge ref_clk_in);
      if (d) dn <= 1'b1; else up <= 1'b1;
      wait_st(d ? PSSC_IDLE : PSSC_ON, 3'h0);
      dn <= 1'b0;
      up <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      err_count++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      repeat (8) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      for (int a = 13; a <= 16; a++) rd_chk(8'(a), 24'h0);
      wr(1'b1, `PSSC_OFS_RAIL_STEP, 24'hf8cc1a);
      rd_chk(`PSSC_OFS_RAIL_STEP, 24'h0);
      pso <= 1'b1;
      wr(1'b1, `PSSC_OFS_RAIL_STEP, 24'hf8cc1a);
      rd_chk(`PSSC_OFS_RAIL_STEP, 24'h08cc1a);
      wr(1'b0, 8'h11, 24'h123456);
      rd_chk(8'h11, 24'h0);
      wr(1'b0, `PSSC_OFS_PU_DELAY, 24'h002c45);
      wr(1'b0, `PSSC_OFS_RST_PGWAIT, 24'h00d043);
      rd_chk(`PSSC_OFS_PU_DELAY, 24'h002c45);
      // power-up held at step 3 by power-good
      @(posedge ref_clk_in);
      up <= 1'b1;
      wait_st(PSSC_UP_PG, 3'h3);
      up <= 1'b0;
      repeat (20) @(posedge ref_clk_in);
      #1 cmp("pg wait", 24'(PSSC_UP_PG), 24'(st));
      hold <= 1'b0;
      wait_st(PSSC_ON, 3'h0);
      cmp_ev(0, 3'h1);
      cmp_ev(1, 3'h3);
      cmp_ev(5, 3'h2);
      for (int s = 1; s < 8; s++) cmp("delay", 24'(ms[s] * TICK + 1), 24'(dly[s]));
      pulse_up_down(1'b1);
      repeat (3) @(posedge ref_clk_in);
      cmp_ev(3, 3'h1);
      cmp_ev(4, 3'h7);
      cmp_ev(2, 3'h4);
      // faults on rail b with recovery off
      pulse_up_down(1'b0);
      flt <= 5'b00010;
      repeat (5) @(posedge ref_clk_in);
      #1 cmp("irq tw", 24'h1, 24'(irq));
      #1 cmp("b on tw", 24'h1, 24'(b_en));
      imask <= 5'b00010;
      repeat (5) @(posedge ref_clk_in);
      #1 cmp("irq masked", 24'h0, 24'(irq));
      imask <= 5'b11111;
      flt <= 5'b00001;
      repeat (5) @(posedge ref_clk_in);
      #1 cmp("irq tsd", 24'h1, 24'(irq));
      #1 cmp("b off tsd", 24'h0, 24'(b_en));
      flt <= '0;
      imask <= '0;
      // fault with recovery on
      wr(1'b1, `PSSC_OFS_RAIL_STEP, 24'h04cc1a);
      pulse_up_down(1'b1);
      pulse_up_down(1'b0);
      flt <= 5'b00100;
      wait_st(PSSC_IDLE, 3'h0);
      cmp("recovery", 24'h1, 24'(rec_seen));
      flt <= '0;
      tally_and_finish();
   end
endmodule
